// file: rtl/error_clear_gear.sv
// Position front end: electronic gear, error counter and its clear logic, Avalon-MM registers
`timescale 1ns/10ps
module error_clear_gear #(
    parameter int ERR_W = 32,
    parameter int LINES = gear_pkg::ENCODER_LINES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Clear pin from the host controller
    input wire logic error_counter_clear_n,
    // Drive state from neighbouring logic
    input wire logic servo_on,
    input wire logic over_travel,
    input wire logic zero_clamp,
    // Decoded reference pulses and encoder feedback pulses
    input wire logic ref_pulse,
    input wire logic ref_dir,
    input wire logic fb_pulse,
    input wire logic fb_dir,
    // To the position loop
    output logic signed [ERR_W-1:0] position_error,
    output logic position_loop_enable
);
    localparam int REV_COUNTS = LINES * gear_pkg::QUAD_FACTOR;
    localparam int REV_W = $clog2(REV_COUNTS);

    // Register file and active configuration
    gear_pkg::param_set_t regs, next_regs;
    gear_pkg::active_cfg_t active, next_active;
    logic restart_req, next_restart_req;
    logic next_waitrequest;
    logic [31:0] next_readdata;
    logic bus_req, bus_done;

    // Clear pin synchroniser
    logic clr_s1, clr_s2, clr_s3, clr_pin_low, next_clr_pin_low;

    // Error path
    logic signed [ERR_W-1:0] next_error;
    logic next_loop_enable;
    logic [15:0] pending, next_pending;
    logic pending_dir, next_pending_dir;
    logic [REV_W-1:0] fb_phase, next_fb_phase;
    logic signed [31:0] revs, next_revs;
    logic auto_clear, clear_now, scaler_start, scaler_busy, delta_valid;
    logic signed [32:0] delta;
    logic [31:0] num_calc, den_calc;

    assign bus_req = read | write;
    assign bus_done = bus_req & ~waitrequest;

    // Ratio that a restart brings into force
    always_comb begin
        if (regs.gear_width != 16'h0000) begin
            num_calc = 32'(regs.num_high) * 32'(gear_pkg::SPLIT_WEIGHT) + 32'(regs.num_low);
            den_calc = 32'(regs.den_high) * 32'(gear_pkg::SPLIT_WEIGHT) + 32'(regs.den_low);
        end else begin
            num_calc = 32'(regs.num_short);
            den_calc = 32'(regs.den_short);
        end
    end

    // Register writes, restart and read data
    always_comb begin
        next_regs = regs;
        next_active = active;
        next_restart_req = 1'b0;
        next_readdata = readdata;
        // Answer on the second cycle of a request, then drop the answer
        next_waitrequest = ~(bus_req & waitrequest);
        if (restart_req) begin
            // Staged values only enter service here
            next_active.clear_mode = regs.clear_mode[1:0];
            next_active.wide = (regs.gear_width != 16'h0000);
            next_active.num = num_calc;
            next_active.den = (den_calc == 32'h0000_0000) ? 32'h0000_0001 : den_calc;
        end
        if (write & bus_done) begin
            unique case (address)
                gear_pkg::OFS_CLEAR_MODE: next_regs.clear_mode = writedata[15:0];
                gear_pkg::OFS_GEAR_WIDTH: next_regs.gear_width = writedata[15:0];
                gear_pkg::OFS_NUM_SHORT: next_regs.num_short = writedata[15:0];
                gear_pkg::OFS_DEN_SHORT: next_regs.den_short = writedata[15:0];
                gear_pkg::OFS_NUM_HIGH: next_regs.num_high = writedata[15:0];
                gear_pkg::OFS_NUM_LOW: next_regs.num_low = writedata[15:0];
                gear_pkg::OFS_DEN_HIGH: next_regs.den_high = writedata[15:0];
                gear_pkg::OFS_DEN_LOW: next_regs.den_low = writedata[15:0];
                gear_pkg::OFS_CONTROL: next_restart_req = writedata[gear_pkg::CTRL_RESTART_BIT];
                default: ;
            endcase
        end
        if (read & waitrequest) begin
            unique case (address)
                gear_pkg::OFS_CLEAR_MODE: next_readdata = {16'h0000, regs.clear_mode};
                gear_pkg::OFS_GEAR_WIDTH: next_readdata = {16'h0000, regs.gear_width};
                gear_pkg::OFS_NUM_SHORT: next_readdata = {16'h0000, regs.num_short};
                gear_pkg::OFS_DEN_SHORT: next_readdata = {16'h0000, regs.den_short};
                gear_pkg::OFS_NUM_HIGH: next_readdata = {16'h0000, regs.num_high};
                gear_pkg::OFS_NUM_LOW: next_readdata = {16'h0000, regs.num_low};
                gear_pkg::OFS_DEN_HIGH: next_readdata = {16'h0000, regs.den_high};
                gear_pkg::OFS_DEN_LOW: next_readdata = {16'h0000, regs.den_low};
                gear_pkg::OFS_STATUS: begin
                    next_readdata = 32'h0000_0000;
                    next_readdata[gear_pkg::STAT_CLEAR_BIT] = clear_now;
                    next_readdata[gear_pkg::STAT_LOOP_BIT] = position_loop_enable;
                    next_readdata[gear_pkg::STAT_WIDTH_BIT] = active.wide;
                    next_readdata[gear_pkg::STAT_BUSY_BIT] = scaler_busy;
                end
                gear_pkg::OFS_ERROR: next_readdata = 32'(position_error);
                gear_pkg::OFS_REVS: next_readdata = revs;
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regs <= {gear_pkg::RST_CLEAR_MODE, gear_pkg::RST_GEAR_WIDTH,
                     gear_pkg::RST_NUM_SHORT, gear_pkg::RST_DEN_SHORT,
                     gear_pkg::RST_NUM_HIGH, gear_pkg::RST_NUM_LOW,
                     gear_pkg::RST_DEN_HIGH, gear_pkg::RST_DEN_LOW};
            active <= {2'(gear_pkg::RST_CLEAR_MODE), 1'b0,
                       32'(gear_pkg::RST_NUM_SHORT), 32'(gear_pkg::RST_DEN_SHORT)};
            restart_req <= 1'b0;
            readdata <= 32'h0000_0000;
            waitrequest <= 1'b1;
        end else if (ce) begin
            regs <= next_regs;
            active <= next_active;
            restart_req <= next_restart_req;
            readdata <= next_readdata;
            waitrequest <= next_waitrequest;
        end
    end

    // Pin level counts once the second and third stages agree
    always_comb begin
        next_clr_pin_low = clr_pin_low;
        if (clr_s2 == clr_s3) begin
            next_clr_pin_low = ~clr_s3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clr_s1 <= 1'b1;
            clr_s2 <= 1'b1;
            clr_s3 <= 1'b1;
            clr_pin_low <= 1'b0;
        end else if (ce) begin
            clr_s1 <= error_counter_clear_n;
            clr_s2 <= clr_s1;
            clr_s3 <= clr_s2;
            clr_pin_low <= next_clr_pin_low;
        end
    end

    // Automatic clear by mode
    always_comb begin
        unique case (gear_pkg::clear_mode_t'(active.clear_mode))
            gear_pkg::CLR_ON_SERVO_OFF: auto_clear = ~servo_on;
            gear_pkg::CLR_NEVER: auto_clear = 1'b0;
            gear_pkg::CLR_ON_OFF_OR_OT: auto_clear = (~servo_on | over_travel) & ~zero_clamp;
            default: auto_clear = 1'b0;
        endcase
    end

    assign clear_now = clr_pin_low | auto_clear;
    assign scaler_start = ~clear_now & ~scaler_busy & ~delta_valid & (pending != 16'h0000);

    gear_scaler #(
        .W(32)
    ) u_scaler (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .flush(clear_now),
        .num(active.num),
        .den(active.den),
        .start(scaler_start),
        .dir(pending_dir),
        .busy(scaler_busy),
        .delta_valid(delta_valid),
        .delta(delta)
    );

    // Reference units queue, error counter and feedback position
    always_comb begin
        next_pending = pending;
        next_pending_dir = pending_dir;
        next_error = position_error;
        next_fb_phase = fb_phase;
        next_revs = revs;
        next_loop_enable = ~clear_now;
        // Queue reference units of one direction while the scaler is busy
        if (scaler_start) begin
            next_pending = pending - 16'h0001;
        end
        if (ref_pulse) begin
            if (next_pending == 16'h0000 || ref_dir == pending_dir) begin
                next_pending_dir = ref_dir;
                next_pending = next_pending + 16'h0001;
            end else begin
                next_pending = next_pending - 16'h0001;
            end
        end
        // Scaled reference in, feedback out
        if (delta_valid) begin
            next_error = next_error + ERR_W'(delta);
        end
        if (fb_pulse) begin
            next_error = fb_dir ? next_error + ERR_W'(1) : next_error - ERR_W'(1);
            // Revolution is lines times four counts
            if (!fb_dir) begin
                if (fb_phase == REV_W'(REV_COUNTS - 1)) begin
                    next_fb_phase = '0;
                    next_revs = revs + 32'sd1;
                end else begin
                    next_fb_phase = fb_phase + REV_W'(1);
                end
            end else if (fb_phase == '0) begin
                next_fb_phase = REV_W'(REV_COUNTS - 1);
                next_revs = revs - 32'sd1;
            end else begin
                next_fb_phase = fb_phase - REV_W'(1);
            end
        end
        if (clear_now) begin
            next_error = '0;
            next_pending = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending <= 16'h0000;
            pending_dir <= 1'b0;
            position_error <= '0;
            position_loop_enable <= 1'b0;
            fb_phase <= '0;
            revs <= 32'sd0;
        end else if (ce) begin
            pending <= next_pending;
            pending_dir <= next_pending_dir;
            position_error <= next_error;
            position_loop_enable <= next_loop_enable;
            fb_phase <= next_fb_phase;
            revs <= next_revs;
        end
    end
endmodule

// file: rtl/gear_pkg.sv
// Constants, register map and carrier types for the error clear and electronic gear block
// Notes on behaviour
// - While the clear input is low the position error counter is forced to zero.
// - While the clear input is asserted the position loop is suspended.
// - Clear mode: on servo-off only; never; on servo-off or over-travel unless zero clamp.
// - Gear width setting picks the 16-bit pair or the 32-bit split parameters.
// - 16-bit mode scales reference pulses by short numerator over short denominator.
// - 32-bit mode ratio is (high*10000+low) over (high*10000+low).
// - One motor revolution is encoder lines times four feedback pulses.
// - Each reference pulse is one reference unit converted through the gear ratio.
package gear_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [5:0] OFS_CLEAR_MODE = 6'h00;
    localparam logic [5:0] OFS_GEAR_WIDTH = 6'h04;
    localparam logic [5:0] OFS_NUM_SHORT = 6'h08;
    localparam logic [5:0] OFS_DEN_SHORT = 6'h0C;
    localparam logic [5:0] OFS_NUM_HIGH = 6'h10;
    localparam logic [5:0] OFS_NUM_LOW = 6'h14;
    localparam logic [5:0] OFS_DEN_HIGH = 6'h18;
    localparam logic [5:0] OFS_DEN_LOW = 6'h1C;
    localparam logic [5:0] OFS_CONTROL = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;
    localparam logic [5:0] OFS_ERROR = 6'h28;
    localparam logic [5:0] OFS_REVS = 6'h2C;

    // Field positions
    localparam int CTRL_RESTART_BIT = 0;
    localparam int STAT_CLEAR_BIT = 0;
    localparam int STAT_LOOP_BIT = 1;
    localparam int STAT_WIDTH_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;

    // Reset values of the parameter registers
    localparam logic [15:0] RST_CLEAR_MODE = 16'h0000;
    localparam logic [15:0] RST_GEAR_WIDTH = 16'h0000;
    localparam logic [15:0] RST_NUM_SHORT = 16'h0001;
    localparam logic [15:0] RST_DEN_SHORT = 16'h0001;
    localparam logic [15:0] RST_NUM_HIGH = 16'h0000;
    localparam logic [15:0] RST_NUM_LOW = 16'h0001;
    localparam logic [15:0] RST_DEN_HIGH = 16'h0000;
    localparam logic [15:0] RST_DEN_LOW = 16'h0001;

    // Weight of the high part in the 32-bit gear form
    localparam logic [15:0] SPLIT_WEIGHT = 16'h2710;
    // Encoder lines per revolution and quadrature factor
    localparam int ENCODER_LINES = 32768;
    localparam int QUAD_FACTOR = 4;

    typedef enum logic [1:0] {
        CLR_ON_SERVO_OFF = 2'b00,
        CLR_NEVER = 2'b01,
        CLR_ON_OFF_OR_OT = 2'b10
    } clear_mode_t;

    // Software-written parameter set
    typedef struct packed {
        logic [15:0] clear_mode;
        logic [15:0] gear_width;
        logic [15:0] num_short;
        logic [15:0] den_short;
        logic [15:0] num_high;
        logic [15:0] num_low;
        logic [15:0] den_high;
        logic [15:0] den_low;
    } param_set_t;

    // Parameter values in force since the last restart
    typedef struct packed {
        logic [1:0] clear_mode;
        logic wide;
        logic [31:0] num;
        logic [31:0] den;
    } active_cfg_t;

endpackage

// file: rtl/gear_scaler.sv
// Electronic gear scaler: one reference unit into a signed count of feedback pulses
`timescale 1ns/10ps
module gear_scaler #(
    parameter int W = 32
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic flush,
    // Ratio in force
    input wire logic [W-1:0] num,
    input wire logic [W-1:0] den,
    // One reference unit to convert
    input wire logic start,
    input wire logic dir,
    output logic busy,
    // Result
    output logic delta_valid,
    output logic signed [W:0] delta
);
    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_DIV = 1'b1
    } div_state_t;

    localparam int CW = $clog2(W + 2);

    div_state_t state, next_state;
    logic signed [W:0] rem, next_rem;
    logic [W:0] dividend, next_dividend;
    logic [W:0] quot, next_quot;
    logic [W:0] part, next_part;
    logic neg, next_neg;
    logic [CW-1:0] cnt, next_cnt;
    logic next_valid;
    logic signed [W:0] next_delta;
    logic signed [W+1:0] sum;
    logic [W+1:0] trial;
    logic [W-1:0] den_safe;

    assign busy = (state == S_DIV);

    always_comb begin
        next_state = state;
        next_rem = rem;
        next_dividend = dividend;
        next_quot = quot;
        next_part = part;
        next_neg = neg;
        next_cnt = cnt;
        next_valid = 1'b0;
        next_delta = delta;
        den_safe = (den == '0) ? W'(1) : den;
        // Carry the remainder so the ratio holds exactly over many pulses
        sum = dir ? ((W + 2)'(rem) - (W + 2)'(signed'({1'b0, num})))
                  : ((W + 2)'(rem) + (W + 2)'(signed'({1'b0, num})));
        trial = {part, dividend[W]} - {2'b00, den_safe};
        if (flush) begin
            next_state = S_IDLE;
            next_rem = '0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (start) begin
                        next_neg = sum[W + 1];
                        next_dividend = sum[W + 1] ? (W + 1)'(-sum) : sum[W:0];
                        next_part = '0;
                        next_quot = '0;
                        next_cnt = CW'(W + 1);
                        next_state = S_DIV;
                    end
                end
                S_DIV: begin
                    // Restoring division of the unit sum by the denominator
                    next_dividend = {dividend[W-1:0], 1'b0};
                    if (!trial[W + 1]) begin
                        next_part = trial[W:0];
                        next_quot = {quot[W-1:0], 1'b1};
                    end else begin
                        next_part = {part[W-1:0], dividend[W]};
                        next_quot = {quot[W-1:0], 1'b0};
                    end
                    next_cnt = cnt - CW'(1);
                    if (cnt == CW'(1)) begin
                        next_state = S_IDLE;
                        next_valid = 1'b1;
                        next_delta = neg ? -signed'(next_quot) : signed'(next_quot);
                        next_rem = neg ? -signed'(next_part) : signed'(next_part);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= S_IDLE;
            rem <= '0;
            dividend <= '0;
            quot <= '0;
            part <= '0;
            neg <= 1'b0;
            cnt <= '0;
            delta_valid <= 1'b0;
            delta <= '0;
        end else if (ce) begin
            state <= next_state;
            rem <= next_rem;
            dividend <= next_dividend;
            quot <= next_quot;
            part <= next_part;
            neg <= next_neg;
            cnt <= next_cnt;
            delta_valid <= next_valid;
            delta <= next_delta;
        end
    end
endmodule

// file: verification/gear_monitor.sv
// Checker for the error clear and electronic gear front end
`timescale 1ns/10ps
module gear_monitor #(
    parameter int ERR_W = 32
) (
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rst,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Pins and loop side
    input wire logic error_counter_clear_n,
    input wire logic servo_on,
    input wire logic fb_pulse,
    input wire logic fb_dir,
    input wire logic signed [ERR_W-1:0] position_error,
    input wire logic position_loop_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_clr_zero;
        !error_counter_clear_n [*7] |-> position_error == 0;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("error not cleared");

    property p_clr_loop;
        !error_counter_clear_n [*7] |-> !position_loop_enable;
    endproperty
    a_clr_loop: assert property (p_clr_loop) else $error("loop not held off");

    property p_fb_step;
        fb_pulse && position_loop_enable && error_counter_clear_n && servo_on
            |=> position_error - $past(position_error) == ($past(fb_dir) ? 1 : -1);
    endproperty
    a_fb_step: assert property (p_fb_step) else $error("feedback step wrong");

    property p_reset_state;
        $fell(rst) |-> waitrequest && position_error == 0 && !position_loop_enable;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

    property p_wait_answer;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("no bus answer");

    property p_wait_one;
        !waitrequest |=> waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");

    property p_wait_idle;
        !(read || write) && waitrequest |=> waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("answer without request");

    property p_rd_hold;
        !read |=> $stable(readdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readdata changed");

    c_clear: cover property (!error_counter_clear_n [*7]);
    c_read: cover property (read && !waitrequest);
    c_fb: cover property (fb_pulse && position_loop_enable);
endmodule

bind error_clear_gear gear_monitor #(.ERR_W(ERR_W)) mon (.clk(clk), .rst(rst), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .error_counter_clear_n(error_counter_clear_n), .servo_on(servo_on), .fb_pulse(fb_pulse),
    .fb_dir(fb_dir), .position_error(position_error),
    .position_loop_enable(position_loop_enable));

// file: verification/host_pulse_model.sv
// Host controller model: reference pulses and the clear pin
`timescale 1ns/10ps
module host_pulse_model (
    // Clock
    input wire logic clk,
    // Pins towards the drive
    output logic ref_pulse,
    output logic ref_dir,
    output logic error_counter_clear_n
);
    initial begin
        ref_pulse = 1'b0;
        ref_dir = 1'b0;
        error_counter_clear_n = 1'b1;
    end

    // One pulse per reference unit; gap sets the pace
    task automatic send_units(input int n, input logic dir, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            ref_pulse <= 1'b1;
            ref_dir <= dir;
            @(posedge clk);
            ref_pulse <= 1'b0;
            repeat (gap) @(posedge clk);
        end
    endtask

    task automatic set_clear(input logic lvl);
        @(posedge clk);
        error_counter_clear_n <= lvl;
    endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the error clear and electronic gear front end
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic error_counter_clear_n;
    logic servo_on = 1'b1;
    logic over_travel = 1'b0;
    logic zero_clamp = 1'b0;
    logic ref_pulse;
    logic ref_dir;
    logic fb_pulse = 1'b0;
    logic fb_dir = 1'b0;
    logic signed [31:0] position_error;
    logic position_loop_enable;
    logic [31:0] rd;
    int error_cnt = 0;
    int checks_done = 0;

    always #12.5 clk = ~clk;

    error_clear_gear #(.ERR_W(32), .LINES(2)) DUT (.clk(clk), .rst(rst), .ce(ce),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .error_counter_clear_n(error_counter_clear_n), .servo_on(servo_on),
        .over_travel(over_travel), .zero_clamp(zero_clamp), .ref_pulse(ref_pulse),
        .ref_dir(ref_dir), .fb_pulse(fb_pulse), .fb_dir(fb_dir),
        .position_error(position_error), .position_loop_enable(position_loop_enable));

    host_pulse_model host (.clk(clk), .ref_pulse(ref_pulse), .ref_dir(ref_dir),
        .error_counter_clear_n(error_counter_clear_n));

    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Avalon cycle: held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    task automatic restart;
        bus(1'b1, gear_pkg::OFS_CONTROL, 32'h0000_0001);
        repeat (3) @(posedge clk);
    endtask

    task automatic fb(input int n, input logic dir);
        repeat (n) begin
            @(posedge clk);
            fb_pulse <= 1'b1;
            fb_dir <= dir;
            @(posedge clk);
            fb_pulse <= 1'b0;
        end
    endtask

    task automatic wait_err(input logic [31:0] e);
        int n;
        n = 0;
        while (position_error !== e && n < 120) begin
            @(posedge clk);
            n++;
        end
        chk("position_error", e, position_error);
        if (position_error !== e) report_and_stop();
    endtask

    task automatic zero_err;
        host.set_clear(1'b0);
        repeat (8) @(posedge clk);
        chk("cleared error", 32'h0000_0000, position_error);
        chk("loop enable", 32'h0000_0000, {31'h0, position_loop_enable});
        host.set_clear(1'b1);
        repeat (8) @(posedge clk);
    endtask

    task automatic t_regs;
        logic [15:0] exp [8] = '{gear_pkg::RST_CLEAR_MODE, gear_pkg::RST_GEAR_WIDTH,
            gear_pkg::RST_NUM_SHORT, gear_pkg::RST_DEN_SHORT, gear_pkg::RST_NUM_HIGH,
            gear_pkg::RST_NUM_LOW, gear_pkg::RST_DEN_HIGH, gear_pkg::RST_DEN_LOW};
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 6'(4 * i), 32'h0000_0000);
            chk("param reset", {16'h0000, exp[i]}, rd);
        end
        bus(1'b0, 6'h30, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, rd);
        bus(1'b1, gear_pkg::OFS_NUM_SHORT, 32'hFFFF_0005);
        bus(1'b0, gear_pkg::OFS_NUM_SHORT, 32'h0000_0000);
        chk("num readback", 32'h0000_0005, rd);
        fb(8, 1'b0);
        wait_err(32'hFFFF_FFF8);
        bus(1'b0, gear_pkg::OFS_REVS, 32'h0000_0000);
        chk("revolutions", 32'h0000_0001, rd);
    endtask

    task automatic t_gear16;
        zero_err();
        bus(1'b1, gear_pkg::OFS_DEN_SHORT, 32'h0000_0002);
        host.send_units(1, 1'b0, 0);
        wait_err(32'h0000_0001);
        restart();
        zero_err();
        host.send_units(2, 1'b0, 3);
        wait_err(32'h0000_0005);
        host.send_units(1, 1'b1, 0);
        wait_err(32'h0000_0003);
    endtask

    task automatic t_gear32;
        bus(1'b1, gear_pkg::OFS_GEAR_WIDTH, 32'h0000_0001);
        bus(1'b1, gear_pkg::OFS_NUM_HIGH, 32'h0000_0001);
        bus(1'b1, gear_pkg::OFS_NUM_LOW, 32'h0000_0002);
        bus(1'b1, gear_pkg::OFS_DEN_HIGH, 32'h0000_0000);
        bus(1'b1, gear_pkg::OFS_DEN_LOW, 32'h0000_1389);
        restart();
        bus(1'b0, gear_pkg::OFS_STATUS, 32'h0000_0000);
        chk("wide status", 32'h0000_0001, {31'h0, rd[gear_pkg::STAT_WIDTH_BIT]});
        zero_err();
        host.send_units(3, 1'b0, 1);
        wait_err(32'h0000_0006);
    endtask

    task automatic t_clear_pin;
        zero_err();
        fb(2, 1'b1);
        wait_err(32'h0000_0002);
        host.set_clear(1'b0);
        repeat (8) @(posedge clk);
        host.send_units(2, 1'b0, 0);
        repeat (40) @(posedge clk);
        chk("error in clear", 32'h0000_0000, position_error);
        chk("loop in clear", 32'h0000_0000, {31'h0, position_loop_enable});
        bus(1'b0, gear_pkg::OFS_STATUS, 32'h0000_0000);
        chk("clear status", 32'h0000_0001, {31'h0, rd[gear_pkg::STAT_CLEAR_BIT]});
        host.set_clear(1'b1);
        repeat (50) @(posedge clk);
        chk("error after clear", 32'h0000_0000, position_error);
        chk("loop after clear", 32'h0000_0001, {31'h0, position_loop_enable});
    endtask

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, gear_pkg::OFS_CLEAR_MODE, 32'(m));
            restart();
            zero_err();
            fb(1, 1'b1);
            wait_err(32'h0000_0001);
            servo_on <= 1'b0;
            repeat (8) @(posedge clk);
            chk("servo off", m[0] ? 32'h0000_0001 : 32'h0000_0000, position_error);
            servo_on <= 1'b1;
            zero_err();
            fb(1, 1'b1);
            wait_err(32'h0000_0001);
            over_travel <= 1'b1;
            zero_clamp <= 1'b1;
            repeat (8) @(posedge clk);
            chk("clamped travel", 32'h0000_0001, position_error);
            zero_clamp <= 1'b0;
            repeat (8) @(posedge clk);
            chk("over travel", (m == 2) ? 32'h0000_0000 : 32'h0000_0001, position_error);
            over_travel <= 1'b0;
        end
    endtask

    task automatic t_freeze;
        zero_err();
        host.send_units(1, 1'b0, 0);
        repeat (5) @(posedge clk);
        ce <= 1'b0;
        repeat (60) @(posedge clk);
        chk("frozen", 32'h0000_0000, position_error);
        ce <= 1'b1;
        wait_err(32'h0000_0002);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, gear_pkg::OFS_CLEAR_MODE, 32'h0000_0000);
        chk("mode reset", 32'(gear_pkg::RST_CLEAR_MODE), rd);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_gear16();
        t_gear32();
        t_clear_pin();
        t_modes();
        t_freeze();
        report_and_stop();
    end
endmodule
